/* File: inc/awd_pkg.sv */
// shared constants and types for the converter window detector
package awd_pkg;
   // special-function register addresses
   localparam logic [7:0] AWD_ADDR_CONFIG = 8'h00_BC;
   localparam logic [7:0] AWD_ADDR_RESULT = 8'h00_BE;
   localparam logic [7:0] AWD_ADDR_CONTROL = 8'h00_E8;
   localparam logic [7:0] AWD_ADDR_GT_LIMIT = 8'h00_C4;
   localparam logic [7:0] AWD_ADDR_LT_LIMIT = 8'h00_C6;
   // values after reset
   localparam logic [7:0] AWD_RST_CONFIG = 8'h00_F8;
   localparam logic [7:0] AWD_RST_CONTROL = 8'h00_00;
   localparam logic [7:0] AWD_RST_RESULT = 8'h00_00;
   localparam logic [7:0] AWD_RST_GT_LIMIT = 8'h00_00;
   localparam logic [7:0] AWD_RST_LT_LIMIT = 8'h00_00;
   // control register bit positions
   localparam int AWD_CN_EN = 7;
   localparam int AWD_CN_TM = 6;
   localparam int AWD_CN_DONE = 5;
   localparam int AWD_CN_BUSY = 4;
   localparam int AWD_CN_WIN = 3;
   // config register field positions
   localparam int AWD_CF_DIV_LSB = 3;
   localparam int AWD_CF_DIV_W = 5;
   // cycle counts in converter clock ticks
   localparam logic [3:0] AWD_CONV_TICKS = 4'h8;
   localparam logic [3:0] AWD_TRACK_TICKS = 4'h3;
   // start source codes
   localparam logic [2:0] AWD_CM_BUSY_WRITE = 3'h0;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } awd_sfr_req_type;

   typedef enum logic [1:0] {
      AWD_IDLE = 2'b01,
      AWD_CONV = 2'b10
   } awd_state_type;
endpackage

/* File: hw/awd_sar_divider.sv */
// converter clock enable from the system clock
`timescale 1ns/1ps
module awd_sar_divider #(
   parameter int DIV_W = 5
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [DIV_W-1:0] div_i,
   // enable pulse
   output logic tick_o
);
   import awd_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
   } awd_div_state_type;

   awd_div_state_type s_q, s_d;

   // restarting from div_i keeps the first tick a full period after start
   always_comb begin
      s_d = s_q;
      if (!run_i || s_q.cnt == '0) begin
         s_d.cnt = div_i;
      end else begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   assign tick_o = run_i && (s_q.cnt == '0);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   property p_tick_period;
      @(posedge clk_sys_i) disable iff (rst_i)
         (tick_o && run_i && div_i == DIV_W'(1) && $stable(div_i)) |=> !tick_o;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick too early");
endmodule

/* File: hw/awd_window_detector.sv */
// converter sequencing, result register and window compare
// How it works
// - every finished conversion is compared with both limits, no software start needed
// - window flag sits in the control register where software can poll it
// - limit ordering alone picks inside-window or outside-window detection
// - single-ended mode compares result and limits as unsigned bytes
// - less-than above greater-than: flag when result strictly between them
// - differential mode compares result and limits as signed bytes
// - outside setting: flag when result below lower or above upper bound
// - divider zero: conversion spans at least eight system clocks
// - converter clock is system clock divided by five-bit divider plus one
`timescale 1ns/1ps
module awd_window_detector (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // special-function register port
   input wire awd_pkg::awd_sfr_req_type sfr_req_i,
   output logic [7:0] sfr_rdata_o,
   // converter side
   input wire logic [7:0] sar_code_i,
   input wire logic diff_mode_i,
   input wire logic [2:0] timer_ovf_i,
   input wire logic ext_start_i,
   output logic tracking_o,
   output logic sar_tick_o,
   // flags toward the core
   output logic conv_done_flag_o,
   output logic window_match_flag_o
);
   import awd_pkg::*;

   typedef struct packed {
      awd_state_type state;
      logic [3:0] cnt;
      logic [7:0] control;
      logic [7:0] config_r;
      logic [7:0] result;
      logic [7:0] gt;
      logic [7:0] lt;
      logic [7:0] rdata;
      logic ext_q;
   } awd_core_state_type;

   awd_core_state_type s_q, s_d;
   logic tick;
   logic conv_end;
   logic start;
   logic cn_wr;
   logic [3:0] limit;

   // flipping the sign bit maps two's complement order onto unsigned order
   function automatic logic [7:0] order_key(input logic [7:0] v, input logic diff);
      order_key = diff ? {~v[7], v[6:0]} : v;
   endfunction

   function automatic logic window_hit(input logic [7:0] res, input logic [7:0] gt,
                                       input logic [7:0] lt, input logic diff);
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] l;
      r = order_key(res, diff);
      g = order_key(gt, diff);
      l = order_key(lt, diff);
      if (l > g) begin
         window_hit = (r > g) && (r < l);
      end else begin
         window_hit = (r < l) || (r > g);
      end
   endfunction

   function automatic logic start_pick(input logic [2:0] cm, input logic busy_wr,
                                       input logic [2:0] ovf, input logic ext_rise);
      if (cm[2]) begin
         start_pick = ext_rise;
      end else if (cm == AWD_CM_BUSY_WRITE) begin
         start_pick = busy_wr;
      end else begin
         start_pick = ovf[cm[1:0] - 2'd1];
      end
   endfunction

   awd_sar_divider #(
      .DIV_W(AWD_CF_DIV_W)
   ) u_div (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .run_i(s_q.state == AWD_CONV),
      .div_i(s_q.config_r[AWD_CF_DIV_LSB +: AWD_CF_DIV_W]),
      .tick_o(tick)
   );

   assign cn_wr = sfr_req_i.wr && (sfr_req_i.addr == AWD_ADDR_CONTROL);
   // low-power track mode spends three extra converter clocks tracking
   assign limit = s_q.control[AWD_CN_TM] ? (AWD_CONV_TICKS + AWD_TRACK_TICKS) : AWD_CONV_TICKS;
   assign conv_end = (s_q.state == AWD_CONV) && tick && (s_q.cnt == limit - 4'd1);
   assign start = s_q.control[AWD_CN_EN] && (s_q.state == AWD_IDLE)
      && start_pick(s_q.control[2:0], cn_wr && sfr_req_i.wdata[AWD_CN_BUSY],
                    timer_ovf_i, ext_start_i && !s_q.ext_q);

   always_comb begin
      s_d = s_q;
      s_d.ext_q = ext_start_i;
      // register writes
      if (sfr_req_i.wr) begin
         case (sfr_req_i.addr)
            AWD_ADDR_CONTROL: begin
               s_d.control = {sfr_req_i.wdata[7:5], s_q.control[AWD_CN_BUSY],
                              sfr_req_i.wdata[3:0]};
            end
            AWD_ADDR_CONFIG: begin
               s_d.config_r = {sfr_req_i.wdata[7:3], 1'b0, sfr_req_i.wdata[1:0]};
            end
            AWD_ADDR_RESULT: begin
               s_d.result = sfr_req_i.wdata;
            end
            AWD_ADDR_GT_LIMIT: begin
               s_d.gt = sfr_req_i.wdata;
            end
            AWD_ADDR_LT_LIMIT: begin
               s_d.lt = sfr_req_i.wdata;
            end
            default: begin
            end
         endcase
      end
      // sequencer
      case (s_q.state)
         AWD_IDLE: begin
            s_d.cnt = '0;
            if (start) begin
               s_d.state = AWD_CONV;
               s_d.control[AWD_CN_BUSY] = 1'b1;
            end
         end
         AWD_CONV: begin
            if (!s_q.control[AWD_CN_EN]) begin
               // disabling aborts the conversion and leaves the result alone
               s_d.state = AWD_IDLE;
               s_d.control[AWD_CN_BUSY] = 1'b0;
            end else if (conv_end) begin
               s_d.state = AWD_IDLE;
               s_d.control[AWD_CN_BUSY] = 1'b0;
               s_d.result = sar_code_i;
               // hardware set wins over a same-cycle software clear
               s_d.control[AWD_CN_DONE] = 1'b1;
               if (window_hit(sar_code_i, s_q.gt, s_q.lt, diff_mode_i)) begin
                  s_d.control[AWD_CN_WIN] = 1'b1;
               end
            end else if (tick) begin
               s_d.cnt = s_q.cnt + 4'd1;
            end
         end
         default: begin
            s_d.state = AWD_IDLE;
         end
      endcase
      // registered read answer
      if (sfr_req_i.rd) begin
         case (sfr_req_i.addr)
            AWD_ADDR_CONTROL: s_d.rdata = s_q.control;
            AWD_ADDR_CONFIG: s_d.rdata = s_q.config_r;
            AWD_ADDR_RESULT: s_d.rdata = s_q.result;
            AWD_ADDR_GT_LIMIT: s_d.rdata = s_q.gt;
            AWD_ADDR_LT_LIMIT: s_d.rdata = s_q.lt;
            default: s_d.rdata = 8'h00_00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_q.state <= AWD_IDLE;
         s_q.cnt <= '0;
         s_q.control <= AWD_RST_CONTROL;
         s_q.config_r <= AWD_RST_CONFIG;
         s_q.result <= AWD_RST_RESULT;
         s_q.gt <= AWD_RST_GT_LIMIT;
         s_q.lt <= AWD_RST_LT_LIMIT;
         s_q.rdata <= 8'h00_00;
         s_q.ext_q <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sfr_rdata_o = s_q.rdata;
   assign tracking_o = s_q.control[AWD_CN_EN] && (s_q.state == AWD_IDLE);
   assign sar_tick_o = tick;
   assign conv_done_flag_o = s_q.control[AWD_CN_DONE];
   assign window_match_flag_o = s_q.control[AWD_CN_WIN];

   property p_auto_compare;
      @(posedge clk_sys_i) disable iff (rst_i)
         (conv_end && s_q.control[AWD_CN_EN] && window_hit(sar_code_i, s_q.gt, s_q.lt,
          diff_mode_i)) |=> window_match_flag_o;
   endproperty
   a_auto_compare: assert property (p_auto_compare) else $error("hit not flagged");

   property p_poll_read;
      @(posedge clk_sys_i) disable iff (rst_i)
         (sfr_req_i.rd && sfr_req_i.addr == AWD_ADDR_CONTROL)
         |=> sfr_rdata_o[AWD_CN_WIN] == $past(window_match_flag_o);
   endproperty
   a_poll_read: assert property (p_poll_read) else $error("flag not readable");

   property p_unsigned_inside;
      @(posedge clk_sys_i) disable iff (rst_i)
         (conv_end && s_q.control[AWD_CN_EN] && !diff_mode_i && s_q.lt > s_q.gt
          && sar_code_i > s_q.gt && sar_code_i < s_q.lt) |=> window_match_flag_o;
   endproperty
   a_unsigned_inside: assert property (p_unsigned_inside) else $error("inside missed");

   property p_inside_only;
      @(posedge clk_sys_i) disable iff (rst_i)
         (conv_end && !diff_mode_i && s_q.lt > s_q.gt && !window_match_flag_o
          && !(sar_code_i > s_q.gt && sar_code_i < s_q.lt) && !cn_wr) |=> !window_match_flag_o;
   endproperty
   a_inside_only: assert property (p_inside_only) else $error("false inside hit");

   property p_signed_outside;
      @(posedge clk_sys_i) disable iff (rst_i)
         (conv_end && s_q.control[AWD_CN_EN] && diff_mode_i
          && $signed(s_q.lt) <= $signed(s_q.gt)
          && ($signed(sar_code_i) < $signed(s_q.lt) || $signed(sar_code_i) > $signed(s_q.gt)))
         |=> window_match_flag_o;
   endproperty
   a_signed_outside: assert property (p_signed_outside) else $error("outside missed");

   property p_outside_only;
      @(posedge clk_sys_i) disable iff (rst_i)
         (conv_end && !diff_mode_i && s_q.lt <= s_q.gt && !window_match_flag_o && !cn_wr
          && sar_code_i >= s_q.lt && sar_code_i <= s_q.gt) |=> !window_match_flag_o;
   endproperty
   a_outside_only: assert property (p_outside_only) else $error("false outside hit");

   property p_min_length;
      @(posedge clk_sys_i) disable iff (rst_i)
         (start && s_q.config_r[AWD_CF_DIV_LSB +: AWD_CF_DIV_W] == '0
          && !s_q.control[AWD_CN_TM] && !(cn_wr && !sfr_req_i.wdata[AWD_CN_EN]))
         |=> (s_q.control[AWD_CN_BUSY] || !s_q.control[AWD_CN_EN]) [*8];
   endproperty
   a_min_length: assert property (p_min_length) else $error("conversion too short");

   property p_sticky;
      @(posedge clk_sys_i) disable iff (rst_i)
         (window_match_flag_o && !(cn_wr && !sfr_req_i.wdata[AWD_CN_WIN]))
         |=> window_match_flag_o;
   endproperty
   a_sticky: assert property (p_sticky) else $error("window flag dropped");

   property p_result_load;
      @(posedge clk_sys_i) disable iff (rst_i)
         (conv_end && s_q.control[AWD_CN_EN]) |=> s_q.result == $past(sar_code_i)
         && !s_q.control[AWD_CN_BUSY];
   endproperty
   a_result_load: assert property (p_result_load) else $error("result not stored");
endmodule

/* File: sim/awd_sar_model.sv */
// converter front-end model feeding the result word to the detector
`timescale 1ns/1ps
module awd_sar_model (
   // converter timing from the detector
   input wire logic sar_tick_i,
   // word the bench wants converted
   input wire logic [7:0] code_i,
   // converter output word
   output logic [7:0] sar_code_o
);
   // word only valid on converter ticks; inverse elsewhere so a stray sample shows up
   assign sar_code_o = sar_tick_i ? code_i : ~code_i;
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the converter window detector
`timescale 1ns/1ps
module tb_top;
   import awd_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   awd_sfr_req_type sfr_req_i = '0;
   logic [7:0] sfr_rdata_o;
   logic [7:0] sar_code_i;
   logic [7:0] code_set = 8'h00;
   logic diff_mode_i = 1'b0;
   logic [2:0] timer_ovf_i = 3'h0;
   logic ext_start_i = 1'b0;
   logic tracking_o;
   logic sar_tick_o;
   logic conv_done_flag_o;
   logic window_match_flag_o;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int tick_cnt = 0;
   // row fields: diff nibble, hit nibble, greater-than limit, less-than limit, code
   logic [31:0] tbl [13] = '{32'h0110_2015, 32'h0010_2010, 32'h0010_2020, 32'h0120_100F,
      32'h0120_1021, 32'h0020_1015, 32'h0020_1010, 32'h11FF_1000, 32'h10FF_10FF,
      32'h10FF_1010, 32'h1110_FFFE, 32'h1110_FF11, 32'h1010_FF05};

   awd_window_detector u_awd_window_detector (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .sar_code_i(sar_code_i),
      .diff_mode_i(diff_mode_i), .timer_ovf_i(timer_ovf_i), .ext_start_i(ext_start_i),
      .tracking_o(tracking_o), .sar_tick_o(sar_tick_o),
      .conv_done_flag_o(conv_done_flag_o), .window_match_flag_o(window_match_flag_o));

   awd_sar_model u_awd_sar_model (.sar_tick_i(sar_tick_o), .code_i(code_set),
      .sar_code_o(sar_code_i));

   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic conclude();
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      total_checks++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         err_count++;
      end
   endtask

   // one bus request held for the edge that takes it, then one idle edge so that
   // back-to-back calls never rewrite the request within one time step
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      sfr_req_i = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk_sys_i);
      #1;
      sfr_req_i = '0;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk("sfr_rdata_o", exp, sfr_rdata_o);
   endtask

   // t0 and c0 are the tick and edge counts taken just before the start request
   task automatic wait_done(input int d, input logic tm, input int t0, input int c0);
      int n;
      int tk;
      n = 0;
      tk = int'(AWD_CONV_TICKS);
      if (tm) begin
         tk += int'(AWD_TRACK_TICKS);
      end
      while (conv_done_flag_o !== 1'b1 && n < 500) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      chk("sar ticks", 8'(tk), 8'(tick_cnt - t0));
      chk("conversion cycles", 8'((d + 1) * tk), 8'(cycles - c0 - 1));
   endtask

   task automatic conv(input logic [7:0] c, input int d, input logic [7:0] cv);
      int t0;
      int c0;
      code_set = c;
      t0 = tick_cnt;
      c0 = cycles;
      acc(1'b1, AWD_ADDR_CONTROL, cv);
      wait_done(d, cv[AWD_CN_TM], t0, c0);
   endtask

   // timer-started conversion; the done flag may already stand, so wait a fixed time
   task automatic tconv(input logic [7:0] c);
      code_set = c;
      timer_ovf_i = 3'h1;
      @(posedge clk_sys_i);
      #1;
      timer_ovf_i = 3'h0;
      repeat (12) @(posedge clk_sys_i);
      #1;
   endtask

   always @(posedge clk_sys_i) begin
      cycles++;
      tick_cnt += (sar_tick_o === 1'b1);
      if (cycles == 5000) begin
         err_count++;
         conclude();
      end
   end

   initial begin
      repeat (20) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      rd(AWD_ADDR_CONFIG, AWD_RST_CONFIG);
      rd(AWD_ADDR_CONTROL, AWD_RST_CONTROL);
      rd(AWD_ADDR_GT_LIMIT, AWD_RST_GT_LIMIT);
      rd(AWD_ADDR_LT_LIMIT, AWD_RST_LT_LIMIT);
      rd(AWD_ADDR_RESULT, AWD_RST_RESULT);
      rd(8'h01, 8'h00);
      acc(1'b1, AWD_ADDR_CONFIG, 8'h00);
      foreach (tbl[i]) begin
         diff_mode_i = tbl[i][28];
         acc(1'b1, AWD_ADDR_GT_LIMIT, tbl[i][23:16]);
         acc(1'b1, AWD_ADDR_LT_LIMIT, tbl[i][15:8]);
         acc(1'b1, AWD_ADDR_CONTROL, 8'h80);
         conv(tbl[i][7:0], 0, 8'h90);
         rd(AWD_ADDR_RESULT, tbl[i][7:0]);
         rd(AWD_ADDR_CONTROL, {4'hA, tbl[i][24], 3'h0});
         chk("window_match_flag_o", {7'h0, tbl[i][24]}, {7'h0, window_match_flag_o});
      end
      // a hit followed by a miss leaves the flag up until software clears it
      acc(1'b1, AWD_ADDR_CONTROL, 8'h81);
      tconv(8'hFE);
      rd(AWD_ADDR_CONTROL, 8'hA9);
      tconv(8'h05);
      rd(AWD_ADDR_RESULT, 8'h05);
      rd(AWD_ADDR_CONTROL, 8'hA9);
      acc(1'b1, AWD_ADDR_CONTROL, 8'h80);
      rd(AWD_ADDR_CONTROL, 8'h80);
      chk("tracking_o", 8'h01, {7'h0, tracking_o});
      acc(1'b1, AWD_ADDR_CONFIG, 8'h0C);
      rd(AWD_ADDR_CONFIG, 8'h08);
      conv(8'h05, 1, 8'h90);
      acc(1'b1, AWD_ADDR_CONFIG, 8'h00);
      // track mode stretches the conversion by the extra tracking ticks
      conv(8'h22, 0, 8'hD0);
      rd(AWD_ADDR_CONTROL, 8'hE8);
      // clearing enable mid-conversion aborts: no result, no flags
      acc(1'b1, AWD_ADDR_CONTROL, 8'h80);
      code_set = 8'h3C;
      acc(1'b1, AWD_ADDR_CONTROL, 8'h90);
      acc(1'b1, AWD_ADDR_CONTROL, 8'h00);
      repeat (12) @(posedge clk_sys_i);
      #1;
      rd(AWD_ADDR_CONTROL, 8'h00);
      rd(AWD_ADDR_RESULT, 8'h22);
      chk("tracking_o", 8'h00, {7'h0, tracking_o});
      // hardware start sources: three timer overflows, then the external edge
      for (int m = 1; m < 5; m++) begin
         int t0;
         int c0;
         acc(1'b1, AWD_ADDR_CONTROL, 8'h80 | 8'(m));
         t0 = tick_cnt;
         c0 = cycles;
         if (m < 4) begin
            timer_ovf_i[m-1] = 1'b1;
         end else begin
            ext_start_i = 1'b1;
         end
         @(posedge clk_sys_i);
         #1;
         timer_ovf_i = 3'h0;
         ext_start_i = 1'b0;
         wait_done(0, 1'b0, t0, c0);
         chk("conv_done_flag_o", 8'h01, {7'h0, conv_done_flag_o});
      end
      // a mid-run reset returns registers and flags to their reset values
      rst_i = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      rd(AWD_ADDR_CONTROL, AWD_RST_CONTROL);
      rd(AWD_ADDR_CONFIG, AWD_RST_CONFIG);
      chk("window_match_flag_o", 8'h00, {7'h0, window_match_flag_o});
      conclude();
   end
endmodule
